// [shared/bcr_pkg.sv]
/*
  Constants for the buck regulator control register bank: register
  offsets, field positions, reset values, fuse vector layout, modes.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package bcr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFS_BUCK1_CONTROL      = 8'h35;
  localparam logic [7:0] OFS_BUCK1_LIMIT_TIMING = 8'h36;
  localparam logic [7:0] OFS_BUCK2_RUN_VOLTAGE  = 8'h38;
  localparam logic [7:0] OFS_BUCK2_STBY_VOLTAGE = 8'h39;
  // buck1_control field positions
  localparam int BIT_RUN_EN     = 0;
  localparam int BIT_STBY_EN    = 1;
  localparam int BIT_SLEEP_EN   = 2;
  localparam int BIT_LOW_POWER  = 3;
  localparam int BIT_SLEW_SEL   = 4;
  localparam int BIT_FPWM_SCALE = 5;
  localparam int BIT_FPWM       = 6;
  localparam int BIT_DIS_DISABLE = 7;
  // buck1_limit_timing field positions, and the buck2 voltage code width
  localparam int LIM_LSB        = 0;
  localparam int LIM_W          = 2;
  localparam int BIT_TIMING     = 4;
  localparam int VOLT_W         = 6;
  // reset values
  localparam logic [7:0] RST_BUCK1_CONTROL = 8'h00;
  localparam logic [1:0] RST_LIMIT         = 2'h0;
  localparam logic       RST_TIMING        = 1'h0;
  localparam logic [5:0] RST_VOLTAGE       = 6'h00;
  // fuse vector layout
  localparam int FUSE_W        = 12;
  localparam int FUSE_RUN_EN   = 0;
  localparam int FUSE_SLEW     = 1;
  localparam int FUSE_DIS_DIS  = 2;
  localparam int FUSE_LIM_LSB  = 3;
  localparam int FUSE_VOLT_LSB = 5;
  localparam int FUSE_SCALE_SEL = 11;
  // cycles the synchronised fuse lines settle before they are loaded
  localparam logic [3:0] FUSE_SETTLE_CYCLES = 4'h4;
  // device power modes, driven by the sequencer on the same clock
  typedef enum logic [1:0] {
    MODE_RUN     = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_SLEEP   = 2'b10,
    MODE_OFF     = 2'b11
  } bcr_mode_t;
  // fuse loader states
  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_LOAD = 2'b01,
    LD_DONE = 2'b10
  } bcr_load_t;
endpackage : bcr_pkg

// [verilog/bcr_fuse_loader.sv]
/*
  Fuse loader: synchronises the fuse lines and issues one load pulse
  after reset release, then flags boot as complete.
  Assumes the fuse lines are static once power is up.
*/
`timescale 1ns/1ps
module bcr_fuse_loader
  import bcr_pkg::*;
(
  input  wire logic              ref_clk,    // system clock
  input  wire logic              reset_n,    // sync reset, active low
  input  wire logic [FUSE_W-1:0] fuseIn,     // raw fuse lines
  output logic      [FUSE_W-1:0] fuseSync,   // synchronised fuse lines
  output logic                   fuseLoad,   // one-cycle load pulse
  output logic                   bootDone    // boot complete level
);
  logic      [FUSE_W-1:0] fuseMeta;
  logic      [3:0]        settleCount;
  bcr_load_t              loadState;

  // two-flop crossing; fuses are static so bus skew cannot bite
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fuseMeta <= '0;
      fuseSync <= '0;
    end else begin
      fuseMeta <= fuseIn;
      fuseSync <= fuseMeta;
    end
  end

  // wait for the crossing to settle, load once, then stay done
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      loadState   <= LD_WAIT;
      settleCount <= 4'h0;
      fuseLoad    <= 1'b0;
      bootDone    <= 1'b0;
    end else begin
      fuseLoad <= 1'b0;
      case (loadState)
        LD_WAIT: begin
          settleCount <= settleCount + 4'h1;
          if (settleCount == FUSE_SETTLE_CYCLES) begin
            loadState <= LD_LOAD;
            fuseLoad  <= 1'b1;
          end
        end
        LD_LOAD: begin
          loadState <= LD_DONE;
          bootDone  <= 1'b1;
        end
        LD_DONE: loadState <= LD_DONE;
        default: loadState <= LD_WAIT;
      endcase
    end
  end
endmodule : bcr_fuse_loader

// [verilog/bcr_buck_regs.sv]
/*
  Buck regulator control register bank: first buck control and
  limit/timing registers, second buck run and standby voltage codes,
  fuse loading at power-up and the control levels for the power stage.
  Assumes a same-clock register port with one-cycle strobes and a mode
  input from the power sequencer on the same clock.
*/
// Behaviour
// - run enable bit 0 fuse-loaded, clear disables
// - standby enable bit 1 defaults to run enable
// - sleep enable bit 2, resets 0, async set
// - bit 3 low power in standby/sleep
// - bit 4 slow slew, ignored if fuse select
// - slew bit fuse-loaded, writable after boot
// - bit 5 forces conduction while scaling down
// - bit 6 forces continuous PWM
// - bit 7 set disconnects discharge resistor
// - two-bit current limit, resets 00
// - limit register bit 4 on/off-time scheme
// - second buck run code, six bits, fuse-loaded
// - standby code defaults to run code
// - fuse fields load at power-on, then RW
`timescale 1ns/1ps
module bcr_buck_regs
  import bcr_pkg::*;
(
  input  wire logic              ref_clk,        // 50 MHz system clock
  input  wire logic              reset_n,        // sync reset, active low
  input  wire logic [ADDR_W-1:0] regAddr,        // register address
  input  wire logic [DATA_W-1:0] regWriteData,   // write data
  input  wire logic              regWrite,       // write strobe
  input  wire logic              regRead,        // read strobe
  output logic      [DATA_W-1:0] regReadData,    // read data, next cycle
  input  wire logic [FUSE_W-1:0] fuseIn,         // fuse lines, static
  input  wire logic              sleepEnableSet, // async set of sleep en
  input  wire logic [1:0]        deviceMode,     // power mode, same clock
  input  wire logic              scalingDown,    // falling voltage ramp
  output logic                   bootDone,       // fuse load finished
  output logic                   buck1On,        // buck1 enabled now
  output logic                   buck1LowPower,  // buck1 low-power mode
  output logic                   buck1SlowSlew,  // 12.5 mV per 4 us
  output logic                   buck1Ccm,       // continuous conduction
  output logic                   buck1Discharge, // resistor connected
  output logic [LIM_W-1:0]       buck1CurrentLimit, // limit code
  output logic                   buck1OffTime,   // off-time scheme
  output logic [VOLT_W-1:0]      buck2RunVoltage,   // run code
  output logic [VOLT_W-1:0]      buck2StandbyVoltage // standby code
);
  logic [FUSE_W-1:0] fuseSync;
  logic              fuseLoad;
  logic [7:0]        buck1_control;
  logic [LIM_W-1:0]  currentLimit;
  logic              timingScheme;
  logic              sleepSetMeta;
  logic              sleepSetSync;
  logic              wrCtrl;
  logic              wrLimit;
  logic              wrRun;
  logic              wrStby;
  logic [7:0]        next_readData;
  logic              next_buck1On;
  bcr_mode_t         mode;

  assign mode    = bcr_mode_t'(deviceMode);
  assign wrCtrl  = regWrite && (regAddr == OFS_BUCK1_CONTROL);
  assign wrLimit = regWrite && (regAddr == OFS_BUCK1_LIMIT_TIMING);
  assign wrRun   = regWrite && (regAddr == OFS_BUCK2_RUN_VOLTAGE);
  assign wrStby  = regWrite && (regAddr == OFS_BUCK2_STBY_VOLTAGE);

  // fuse crossing and the one-shot power-up load
  bcr_fuse_loader u_loader (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .fuseIn   (fuseIn),
    .fuseSync (fuseSync),
    .fuseLoad (fuseLoad),
    .bootDone (bootDone)
  );

  // sleep-enable set pin comes from outside, two flops first
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sleepSetMeta <= 1'b0;
      sleepSetSync <= 1'b0;
    end else begin
      sleepSetMeta <= sleepEnableSet;
      sleepSetSync <= sleepSetMeta;
    end
  end

  // run/standby enables: fuse load, then software may clear them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1_control[BIT_RUN_EN]  <= RST_BUCK1_CONTROL[BIT_RUN_EN];
      buck1_control[BIT_STBY_EN] <= RST_BUCK1_CONTROL[BIT_STBY_EN];
    end else if (fuseLoad) begin
      buck1_control[BIT_RUN_EN]  <= fuseSync[FUSE_RUN_EN];
      buck1_control[BIT_STBY_EN] <= fuseSync[FUSE_RUN_EN];
    end else if (wrCtrl) begin
      buck1_control[BIT_RUN_EN]  <= regWriteData[BIT_RUN_EN];
      buck1_control[BIT_STBY_EN] <= regWriteData[BIT_STBY_EN];
    end
  end

  // sleep enable: the set pin wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1_control[BIT_SLEEP_EN] <= RST_BUCK1_CONTROL[BIT_SLEEP_EN];
    end else if (sleepSetSync) begin
      buck1_control[BIT_SLEEP_EN] <= 1'b1;
    end else if (wrCtrl) begin
      buck1_control[BIT_SLEEP_EN] <= regWriteData[BIT_SLEEP_EN];
    end
  end

  // plain read/write mode bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1_control[BIT_LOW_POWER]  <= RST_BUCK1_CONTROL[BIT_LOW_POWER];
      buck1_control[BIT_FPWM_SCALE] <= RST_BUCK1_CONTROL[BIT_FPWM_SCALE];
      buck1_control[BIT_FPWM]       <= RST_BUCK1_CONTROL[BIT_FPWM];
    end else if (wrCtrl) begin
      buck1_control[BIT_LOW_POWER]  <= regWriteData[BIT_LOW_POWER];
      buck1_control[BIT_FPWM_SCALE] <= regWriteData[BIT_FPWM_SCALE];
      buck1_control[BIT_FPWM]       <= regWriteData[BIT_FPWM];
    end
  end

  // slew select: writes before boot completes are dropped so the
  // fuse value cannot be overtaken by an early software write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1_control[BIT_SLEW_SEL] <= RST_BUCK1_CONTROL[BIT_SLEW_SEL];
    end else if (fuseLoad) begin
      buck1_control[BIT_SLEW_SEL] <= fuseSync[FUSE_SLEW];
    end else if (wrCtrl && bootDone) begin
      buck1_control[BIT_SLEW_SEL] <= regWriteData[BIT_SLEW_SEL];
    end
  end

  // discharge disable: fuse-loaded, then read/write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1_control[BIT_DIS_DISABLE] <= RST_BUCK1_CONTROL[BIT_DIS_DISABLE];
    end else if (fuseLoad) begin
      buck1_control[BIT_DIS_DISABLE] <= fuseSync[FUSE_DIS_DIS];
    end else if (wrCtrl) begin
      buck1_control[BIT_DIS_DISABLE] <= regWriteData[BIT_DIS_DISABLE];
    end
  end

  // current limit (fuse-loaded) and timing scheme
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      currentLimit <= RST_LIMIT;
    end else if (fuseLoad) begin
      currentLimit <= fuseSync[FUSE_LIM_LSB +: LIM_W];
    end else if (wrLimit) begin
      currentLimit <= regWriteData[LIM_LSB +: LIM_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timingScheme <= RST_TIMING;
    end else if (wrLimit) begin
      timingScheme <= regWriteData[BIT_TIMING];
    end
  end

  // second buck codes; both take the fuse run code at power-up
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck2RunVoltage <= RST_VOLTAGE;
    end else if (fuseLoad) begin
      buck2RunVoltage <= fuseSync[FUSE_VOLT_LSB +: VOLT_W];
    end else if (wrRun) begin
      buck2RunVoltage <= regWriteData[VOLT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck2StandbyVoltage <= RST_VOLTAGE;
    end else if (fuseLoad) begin
      buck2StandbyVoltage <= fuseSync[FUSE_VOLT_LSB +: VOLT_W];
    end else if (wrStby) begin
      buck2StandbyVoltage <= regWriteData[VOLT_W-1:0];
    end
  end

  // read mux; unused bits and unmapped addresses return zero
  always_comb begin
    next_readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        OFS_BUCK1_CONTROL: next_readData = buck1_control;
        OFS_BUCK1_LIMIT_TIMING: begin
          next_readData[LIM_LSB +: LIM_W] = currentLimit;
          next_readData[BIT_TIMING]       = timingScheme;
        end
        OFS_BUCK2_RUN_VOLTAGE:
          next_readData[VOLT_W-1:0] = buck2RunVoltage;
        OFS_BUCK2_STBY_VOLTAGE:
          next_readData[VOLT_W-1:0] = buck2StandbyVoltage;
        default: next_readData = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

  // enable for the present power mode; off mode never enables
  always_comb begin
    case (mode)
      MODE_RUN:     next_buck1On = buck1_control[BIT_RUN_EN];
      MODE_STANDBY: next_buck1On = buck1_control[BIT_STBY_EN];
      MODE_SLEEP:   next_buck1On = buck1_control[BIT_SLEEP_EN];
      default:      next_buck1On = 1'b0;
    endcase
  end

  // power stage controls, all registered so the stage sees no glitch
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buck1On        <= 1'b0;
      buck1LowPower  <= 1'b0;
      buck1SlowSlew  <= 1'b0;
      buck1Ccm       <= 1'b0;
      buck1Discharge <= 1'b0;
    end else begin
      buck1On       <= next_buck1On;
      buck1LowPower <= buck1_control[BIT_LOW_POWER] &&
                       (mode == MODE_STANDBY || mode == MODE_SLEEP);
      buck1SlowSlew <= buck1_control[BIT_SLEW_SEL] &&
                       !fuseSync[FUSE_SCALE_SEL];
      buck1Ccm      <= buck1_control[BIT_FPWM] ||
                       (buck1_control[BIT_FPWM_SCALE] && scalingDown);
      buck1Discharge <= !next_buck1On &&
                        !buck1_control[BIT_DIS_DISABLE];
    end
  end

  // limit and timing drive the stage straight from their flops
  assign buck1CurrentLimit = currentLimit;
  assign buck1OffTime      = timingScheme;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_readCtrl;
    regRead && regAddr == OFS_BUCK1_CONTROL;
  endsequence

  sequence s_writeSleepClear;
    wrCtrl && !regWriteData[BIT_SLEEP_EN] && sleepSetSync;
  endsequence

  sequence s_fuseLoad;
    fuseLoad;
  endsequence

  ctrl_readback_a: assert property (
    s_readCtrl |=> regReadData == $past(buck1_control))
    else $error("control readback wrong");

  no_read_zero_a: assert property (
    !regRead |=> regReadData == 8'h00)
    else $error("read data outside read cycle");

  limit_unused_zero_a: assert property (
    regRead && regAddr == OFS_BUCK1_LIMIT_TIMING |=>
      regReadData[7:5] == 3'h0 && regReadData[3:2] == 2'h0)
    else $error("unused limit bits not zero");

  sleep_set_wins_a: assert property (
    s_writeSleepClear |=> buck1_control[BIT_SLEEP_EN])
    else $error("sleep set lost to clear");

  slew_fuse_override_a: assert property (
    fuseSync[FUSE_SCALE_SEL] |=> !buck1SlowSlew)
    else $error("slew used while fuse select set");

  low_power_mode_a: assert property (
    mode == MODE_RUN |=> !buck1LowPower)
    else $error("low power in run mode");

  fuse_codes_equal_a: assert property (
    s_fuseLoad |=> buck2StandbyVoltage == buck2RunVoltage
                   ##0 buck1_control[BIT_STBY_EN] ==
                       buck1_control[BIT_RUN_EN])
    else $error("fuse defaults differ");

  slew_early_write_a: assert property (
    wrCtrl && !bootDone && !fuseLoad |=> $stable(buck1_control[BIT_SLEW_SEL]))
    else $error("slew written before boot");

  discharge_off_a: assert property (
    buck1_control[BIT_DIS_DISABLE] && $stable(buck1_control) |=>
      !buck1Discharge)
    else $error("discharge while disabled by bit");

  run_clear_off_a: assert property (
    wrCtrl && !regWriteData[BIT_RUN_EN] && !fuseLoad && mode == MODE_RUN
      ##1 mode == MODE_RUN |=> !buck1On)
    else $error("run clear did not switch off");
endmodule : bcr_buck_regs

// [testbench/bcr_buck_regs_test.sv]
/*
  Self-checking bench for the buck regulator control register bank:
  fuse loading, read/write access, unused bits, mode-dependent
  control levels, current limit, voltage codes and the sleep set pin.
  Assumes the register port of the bank and a 50 MHz clock.
*/
`timescale 1ns/1ps
module bcr_buck_regs_test
  import bcr_pkg::*;
;
  logic              ref_clk        = 1'b0;
  logic              reset_n        = 1'b0;
  logic [ADDR_W-1:0] regAddr        = 8'h00;
  logic [DATA_W-1:0] regWriteData   = 8'h00;
  logic              regWrite       = 1'b0;
  logic              regRead        = 1'b0;
  logic [FUSE_W-1:0] fuseIn         = 12'h557;
  logic              sleepEnableSet = 1'b0;
  logic [1:0]        deviceMode     = 2'h0;
  logic              scalingDown    = 1'b0;
  logic [DATA_W-1:0] regReadData;
  logic              bootDone;
  logic              buck1On;
  logic              buck1LowPower;
  logic              buck1SlowSlew;
  logic              buck1Ccm;
  logic              buck1Discharge;
  logic [LIM_W-1:0]  buck1CurrentLimit;
  logic              buck1OffTime;
  logic [VOLT_W-1:0] buck2RunVoltage;
  logic [VOLT_W-1:0] buck2StandbyVoltage;
  int                fails     = 0;
  int                cmp_count = 0;
  int                cycles    = 0;
  int                i;
  int                j;
  int                k;
  logic [7:0]        ctrlVals [5] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h26};

  bcr_buck_regs bcr_buck_regs_inst (
    .ref_clk            (ref_clk),
    .reset_n            (reset_n),
    .regAddr            (regAddr),
    .regWriteData       (regWriteData),
    .regWrite           (regWrite),
    .regRead            (regRead),
    .regReadData        (regReadData),
    .fuseIn             (fuseIn),
    .sleepEnableSet     (sleepEnableSet),
    .deviceMode         (deviceMode),
    .scalingDown        (scalingDown),
    .bootDone           (bootDone),
    .buck1On            (buck1On),
    .buck1LowPower      (buck1LowPower),
    .buck1SlowSlew      (buck1SlowSlew),
    .buck1Ccm           (buck1Ccm),
    .buck1Discharge     (buck1Discharge),
    .buck1CurrentLimit  (buck1CurrentLimit),
    .buck1OffTime       (buck1OffTime),
    .buck2RunVoltage    (buck2RunVoltage),
    .buck2StandbyVoltage(buck2StandbyVoltage)
  );

  // 20 ns period
  always #10 ref_clk = ~ref_clk;

  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // single bits go through here so no operator widens before the compare
  task chb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask : chb

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr      <= a;
    regWriteData <= d;
    regWrite     <= 1'b1;
    @(posedge ref_clk);
    regWrite     <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe, then drop to 0
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regReadData, e);
    @(posedge ref_clk);
    #1 chk(regReadData, 8'h00);
  endtask : rd

  // reset for 17 cycles, then wait for the fuse load under a bound
  task do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 chb(bootDone, 1'b0);
    chk({2'h0, buck2RunVoltage}, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    for (k = 0; k < 30 && bootDone !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chb(bootDone, 1'b1);
  endtask : do_reset

  // control levels follow the register bits and the present mode
  task out_check(input logic [7:0] c, input logic [1:0] m, input logic sd);
    logic on;
    @(posedge ref_clk);
    deviceMode  <= m;
    scalingDown <= sd;
    wr(OFS_BUCK1_CONTROL, c);
    repeat (3) @(posedge ref_clk);
    #1;
    on = (m == MODE_RUN) ? c[0] : (m == MODE_STANDBY) ? c[1] :
         (m == MODE_SLEEP) ? c[2] : 1'b0;
    chb(buck1On, on);
    chb(buck1LowPower, c[3] & (m == MODE_STANDBY || m == MODE_SLEEP));
    chb(buck1SlowSlew, c[4] & ~fuseIn[11]);
    chb(buck1Ccm, c[6] | (c[5] & sd));
    chb(buck1Discharge, ~on & ~c[7]);
  endtask : out_check

  // main sequence
  initial begin
    do_reset();
    rd(OFS_BUCK1_CONTROL, 8'h93);
    rd(OFS_BUCK1_LIMIT_TIMING, 8'h02);
    rd(OFS_BUCK2_RUN_VOLTAGE, 8'h2A);
    rd(OFS_BUCK2_STBY_VOLTAGE, 8'h2A);
    wr(OFS_BUCK1_CONTROL, 8'hFF);
    rd(OFS_BUCK1_CONTROL, 8'hFF);
    wr(OFS_BUCK1_CONTROL, 8'h00);
    rd(OFS_BUCK1_CONTROL, 8'h00);
    wr(OFS_BUCK1_LIMIT_TIMING, 8'hFF);
    rd(OFS_BUCK1_LIMIT_TIMING, 8'h13);
    wr(OFS_BUCK2_RUN_VOLTAGE, 8'hFF);
    rd(OFS_BUCK2_RUN_VOLTAGE, 8'h3F);
    wr(OFS_BUCK2_STBY_VOLTAGE, 8'hC0);
    rd(OFS_BUCK2_STBY_VOLTAGE, 8'h00);
    wr(8'h37, 8'hFF);
    rd(8'h37, 8'h00);
    // every limit code with both timing schemes, back to back
    for (i = 0; i < 8; i++) begin
      wr(OFS_BUCK1_LIMIT_TIMING, {3'h0, i[2], 2'h0, i[1:0]});
      chk({6'h00, buck1CurrentLimit}, {6'h00, i[1:0]});
      chb(buck1OffTime, i[2]);
    end
    // voltage codes at both ends of the range, kept independent
    for (i = 0; i < 64; i += 21) begin
      wr(OFS_BUCK2_RUN_VOLTAGE, i[7:0]);
      wr(OFS_BUCK2_STBY_VOLTAGE, 8'h3F - i[7:0]);
      chk({2'h0, buck2RunVoltage}, i[7:0]);
      chk({2'h0, buck2StandbyVoltage}, 8'h3F - i[7:0]);
    end
    for (i = 0; i < 5; i++)
      for (j = 0; j < 4; j++)
        for (k = 0; k < 2; k++)
          out_check(ctrlVals[i], j[1:0], k[0]);
    // sleep set pin wins over a software clear while it is held
    wr(OFS_BUCK1_CONTROL, 8'h00);
    sleepEnableSet <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(OFS_BUCK1_CONTROL, 8'h00);
    rd(OFS_BUCK1_CONTROL, 8'h04);
    sleepEnableSet <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(OFS_BUCK1_CONTROL, 8'h00);
    rd(OFS_BUCK1_CONTROL, 8'h00);
    // second power-up with other fuses, scaling-select fuse set
    fuseIn <= 12'hAAA;
    do_reset();
    rd(OFS_BUCK1_CONTROL, 8'h10);
    rd(OFS_BUCK1_LIMIT_TIMING, 8'h01);
    rd(OFS_BUCK2_RUN_VOLTAGE, 8'h15);
    rd(OFS_BUCK2_STBY_VOLTAGE, 8'h15);
    out_check(8'h10, MODE_RUN, 1'b0);
    out_check(8'h1F, MODE_SLEEP, 1'b1);
    report_and_stop();
  end
endmodule : bcr_buck_regs_test
